/* pkg/iox_pkg.sv */
// shared constants and types for the octal i/o expander
package iox_pkg;
  // ---------------------------------------------------------------
  // serial address and byte framing
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_PREFIX   = 5'h1C;  // fixed upper address bits 11100
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT_IDX  = 4'h7;

  // ---------------------------------------------------------------
  // register pointer values and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] REG_IN_LEVEL  = 2'h0;
  localparam logic [1:0] REG_OUT_LEVEL = 2'h1;
  localparam logic [1:0] REG_INVERT    = 2'h2;
  localparam logic [1:0] REG_DIR       = 2'h3;
  localparam logic [1:0] PTR_RST       = 2'h0;
  localparam logic [7:0] OUT_LEVEL_RST = 8'hFF;
  localparam logic [7:0] INVERT_RST    = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'hFF;

  // ---------------------------------------------------------------
  // link-to-core request kinds and link states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    REQ_CMD  = 2'h0,
    REQ_WR   = 2'h1,
    REQ_RD   = 2'h2,
    REQ_STOP = 2'h3
  } iox_req_t;

  typedef enum logic [2:0] {
    LS_IDLE    = 3'h0,
    LS_ADDR    = 3'h1,
    LS_ACK_OUT = 3'h3,
    LS_RECV    = 3'h2,
    LS_SEND    = 3'h6,
    LS_ACK_IN  = 3'h7,
    LS_IGNORE  = 3'h5
  } iox_lstate_t;
endpackage

/* rtl/iox_sync.sv */
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module iox_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             clk_in,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    q_out  <= meta_r;
  end
endmodule
`default_nettype wire

/* rtl/iox_pin_bank.sv */
// eight port pin cells: drivers, input sampling, polarity, change detect
`timescale 1ns/1ps
`default_nettype none
module iox_pin_bank (
  // core clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // register contents
  input  wire logic [7:0] out_level_bits_in,
  input  wire logic [7:0] direction_bits_in,
  input  wire logic [7:0] invert_bits_in,
  // reload of the change-detect reference
  input  wire logic       ref_load_in,
  // port pins
  input  wire logic [7:0] port_pins_in,
  output logic      [7:0] port_pins_out,
  output logic      [7:0] port_pins_oe_out,
  output logic      [7:0] high_side_driver_out,
  output logic      [7:0] low_side_driver_out,
  // sampled levels and change request
  output logic      [7:0] in_level_bits_out,
  output logic            int_req_out
);
  logic [7:0] pin_s;
  logic [7:0] ref_r;
  logic [7:0] diff_w;

  // pins come from outside: two flops before any use
  iox_sync #(.WIDTH(8)) u_pin_sync (
    .clk_in (clk_in),
    .d_in   (port_pins_in),
    .q_out  (pin_s)
  );

  assign int_req_out = |diff_w;

  // -----------------------------------------------------------------
  // one cell per pin
  // -----------------------------------------------------------------
  for (genvar gi = 0; gi < 8; gi++) begin : g_bit
    // inversion only on inputs; level read whatever the direction
    assign in_level_bits_out[gi] = pin_s[gi] ^ (invert_bits_in[gi] & direction_bits_in[gi]);
    // outputs never raise a change
    assign diff_w[gi] = direction_bits_in[gi] & (pin_s[gi] != ref_r[gi]);

    // drivers follow direction and output level
    always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
        port_pins_out[gi]        <= 1'b1;
        port_pins_oe_out[gi]     <= 1'b0;
        high_side_driver_out[gi] <= 1'b0;
        low_side_driver_out[gi]  <= 1'b0;
      end else begin
        port_pins_out[gi]        <= out_level_bits_in[gi];
        port_pins_oe_out[gi]     <= ~direction_bits_in[gi];
        high_side_driver_out[gi] <= ~direction_bits_in[gi] & out_level_bits_in[gi];
        low_side_driver_out[gi]  <= ~direction_bits_in[gi] & ~out_level_bits_in[gi];
      end
    end

    // reference follows the pin only when reloaded
    always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
        ref_r[gi] <= 1'b0;
      end else if (ref_load_in) begin
        ref_r[gi] <= pin_s[gi];
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/iox_expander.sv */
// octal i/o expander: serial slave on the link clock, registers on the core clock
//
// Summary of operation
// - input pins have both high-side and low-side drivers switched off
// - output pins drive high or low side according to the output level bit
// - sda falling while scl high starts a transfer and an address byte
// - matching address is acknowledged by sda low through the ninth clock high
// - one bit per scl pulse; sda change during scl high is start or stop
// - sda rising while scl high ends the current transfer
// - bytes are eight bits plus acknowledge; transmitter releases sda before it
// - every byte received while addressed is acknowledged with sda low
// - on master nack after a read byte, sda is released for the stop
// - own address is 11100 followed by the two address-select pins
// - last address bit one means read, zero means write
// - first byte of a write is the command, stored as register pointer
// - two low command bits pick input, output, inversion or direction register
// - stored pointer stays in force for later reads until a new command
// - input register returns all pin levels; writes to it do nothing
// - output register drives only outputs and reads back its own flops
// - inversion bit one inverts an input pin's sampled level
// - direction bit one makes an input with driver off, zero an output
// - reset sets output and direction to ones, inversion to zeros
// - interrupt on input pin change, cleared by return, input read or stop
// - reset input low forces registers and bus state machine to defaults
// - any number of data bytes follow the command in one write
// - read data captured at the rising edge of the acknowledge clock
`timescale 1ns/1ps
`default_nettype none
module iox_expander (
  // core clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // link clock
  input  wire logic       link_clk_in,
  // serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // address select straps
  input  wire logic       addr_select_low_in,
  input  wire logic       addr_select_high_in,
  // port pins
  input  wire logic [7:0] port_pins_in,
  output logic      [7:0] port_pins_out,
  output logic      [7:0] port_pins_oe_out,
  output logic      [7:0] high_side_driver_out,
  output logic      [7:0] low_side_driver_out,
  // open-drain interrupt, active low
  output logic            int_n_out,
  output logic            int_n_oe_out
);
  // -----------------------------------------------------------------
  // link domain declarations
  // -----------------------------------------------------------------
  logic                 lrst_n;
  logic                 scl_s;
  logic                 sda_s;
  logic                 scl_q;
  logic                 sda_q;
  logic [1:0]           asel_s;
  logic                 ack_s;
  iox_pkg::iox_lstate_t st_r;
  iox_pkg::iox_lstate_t st_nxt;
  logic [3:0]           cnt_r;
  logic [3:0]           cnt_nxt;
  logic [7:0]           sh_r;
  logic [7:0]           sh_nxt;
  logic                 oe_nxt;
  logic                 rw_r;
  logic                 rw_nxt;
  logic                 cmd_phase_r;
  logic                 cmd_phase_nxt;
  logic                 matched_r;
  logic                 matched_nxt;
  logic                 nack_r;
  logic                 nack_nxt;
  logic                 req_go_c;
  iox_pkg::iox_req_t    req_kind_c;
  logic [7:0]           req_data_c;
  logic                 req_tgl_r;
  iox_pkg::iox_req_t    req_kind_r;
  logic [7:0]           req_data_r;

  // -----------------------------------------------------------------
  // core domain declarations
  // -----------------------------------------------------------------
  logic       req_s;
  logic       req_seen_r;
  logic       ack_tgl_r;
  logic [1:0] ptr_r;
  logic [7:0] out_level_r;
  logic [7:0] invert_r;
  logic [7:0] dir_r;
  logic [7:0] core_rdata_r;
  logic       seeded_r;
  logic [7:0] in_level_w;
  logic       int_req_w;

  // -----------------------------------------------------------------
  // link input synchronisers
  // -----------------------------------------------------------------
  iox_sync #(.WIDTH(1)) u_lrst_sync (
    .clk_in (link_clk_in),
    .d_in   (reset_n_in),
    .q_out  (lrst_n)
  );

  iox_sync #(.WIDTH(2)) u_bus_sync (
    .clk_in (link_clk_in),
    .d_in   ({scl_in, sda_in}),
    .q_out  ({scl_s, sda_s})
  );

  // straps held steady by the system during a transfer
  iox_sync #(.WIDTH(2)) u_asel_sync (
    .clk_in (link_clk_in),
    .d_in   ({addr_select_high_in, addr_select_low_in}),
    .q_out  (asel_s)
  );

  iox_sync #(.WIDTH(1)) u_ack_sync (
    .clk_in (link_clk_in),
    .d_in   (ack_tgl_r),
    .q_out  (ack_s)
  );

  // -----------------------------------------------------------------
  // bus event decode
  // -----------------------------------------------------------------
  wire       scl_high_w = scl_s & scl_q;
  wire       start_w    = scl_high_w & sda_q & ~sda_s;
  wire       stop_w     = scl_high_w & ~sda_q & sda_s;
  wire       scl_rise_w = scl_s & ~scl_q;
  wire       scl_fall_w = ~scl_s & scl_q;
  wire [6:0] own_addr_w = {iox_pkg::ADDR_PREFIX, asel_s};
  wire       addr_hit_w = (sh_r[7:1] == own_addr_w);
  wire       byte_done_w = scl_fall_w & (cnt_r == iox_pkg::BITS_PER_BYTE);
  wire       hs_idle_w  = (ack_s == req_tgl_r);

  // line history, taken from synchronised copies only
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // -----------------------------------------------------------------
  // serial slave state machine
  // -----------------------------------------------------------------
  // stop outranks start, start outranks any bit in progress
  always_comb begin
    st_nxt        = st_r;
    cnt_nxt       = cnt_r;
    sh_nxt        = sh_r;
    oe_nxt        = sda_oe_out;
    rw_nxt        = rw_r;
    cmd_phase_nxt = cmd_phase_r;
    matched_nxt   = matched_r;
    nack_nxt      = nack_r;
    req_go_c      = 1'b0;
    req_kind_c    = iox_pkg::REQ_STOP;
    req_data_c    = sh_r;
    if (stop_w) begin
      st_nxt      = iox_pkg::LS_IDLE;
      oe_nxt      = 1'b0;
      matched_nxt = 1'b0;
      req_go_c    = matched_r;
    end else if (start_w) begin
      st_nxt      = iox_pkg::LS_ADDR;
      cnt_nxt     = 4'h0;
      oe_nxt      = 1'b0;
      matched_nxt = 1'b0;
    end else begin
      unique case (st_r)
        iox_pkg::LS_IDLE, iox_pkg::LS_IGNORE: begin
          oe_nxt = 1'b0;
        end
        iox_pkg::LS_ADDR: begin
          if (scl_rise_w) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done_w && addr_hit_w) begin
            oe_nxt        = 1'b1;
            rw_nxt        = sh_r[0];
            cmd_phase_nxt = ~sh_r[0];
            matched_nxt   = 1'b1;
            st_nxt        = iox_pkg::LS_ACK_OUT;
          end else if (byte_done_w) begin
            st_nxt = iox_pkg::LS_IGNORE;
          end
        end
        iox_pkg::LS_ACK_OUT: begin
          if (scl_rise_w && rw_r) begin
            req_go_c   = 1'b1;
            req_kind_c = iox_pkg::REQ_RD;
          end else if (scl_fall_w) begin
            cnt_nxt = 4'h0;
            if (rw_r) begin
              sh_nxt = core_rdata_r;
              oe_nxt = ~core_rdata_r[7];
              st_nxt = iox_pkg::LS_SEND;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = iox_pkg::LS_RECV;
            end
          end
        end
        iox_pkg::LS_RECV: begin
          if (scl_rise_w) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done_w) begin
            req_go_c      = 1'b1;
            req_kind_c    = cmd_phase_r ? iox_pkg::REQ_CMD : iox_pkg::REQ_WR;
            cmd_phase_nxt = 1'b0;
            oe_nxt        = 1'b1;
            st_nxt        = iox_pkg::LS_ACK_OUT;
          end
        end
        iox_pkg::LS_SEND: begin
          if (scl_fall_w && cnt_r == iox_pkg::LAST_BIT_IDX) begin
            oe_nxt = 1'b0;
            st_nxt = iox_pkg::LS_ACK_IN;
          end else if (scl_fall_w) begin
            sh_nxt  = {sh_r[6:0], 1'b0};
            oe_nxt  = ~sh_r[6];
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        iox_pkg::LS_ACK_IN: begin
          if (scl_rise_w) begin
            nack_nxt   = sda_s;
            req_go_c   = ~sda_s;
            req_kind_c = iox_pkg::REQ_RD;
          end else if (scl_fall_w && nack_r) begin
            st_nxt = iox_pkg::LS_IGNORE;
          end else if (scl_fall_w) begin
            sh_nxt  = core_rdata_r;
            oe_nxt  = ~core_rdata_r[7];
            cnt_nxt = 4'h0;
            st_nxt  = iox_pkg::LS_SEND;
          end
        end
        default: begin
          st_nxt = iox_pkg::LS_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // state registers; link reset comes through its own synchroniser
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      st_r        <= iox_pkg::LS_IDLE;
      cnt_r       <= 4'h0;
      sh_r        <= 8'h00;
      sda_oe_out  <= 1'b0;
      rw_r        <= 1'b0;
      cmd_phase_r <= 1'b0;
      matched_r   <= 1'b0;
      nack_r      <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      sh_r        <= sh_nxt;
      sda_oe_out  <= oe_nxt;
      rw_r        <= rw_nxt;
      cmd_phase_r <= cmd_phase_nxt;
      matched_r   <= matched_nxt;
      nack_r      <= nack_nxt;
    end
  end

  // request launch; kind and data stay put until the core answers
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      req_tgl_r  <= 1'b0;
      req_kind_r <= iox_pkg::REQ_STOP;
      req_data_r <= 8'h00;
      sda_out    <= 1'b0;
    end else if (req_go_c && hs_idle_w) begin
      req_tgl_r  <= ~req_tgl_r;
      req_kind_r <= req_kind_c;
      req_data_r <= req_data_c;
    end
  end

  // -----------------------------------------------------------------
  // core side of the request crossing
  // -----------------------------------------------------------------
  iox_sync #(.WIDTH(1)) u_req_sync (
    .clk_in (clk_in),
    .d_in   (req_tgl_r),
    .q_out  (req_s)
  );

  wire req_new_w = (req_s != req_seen_r);
  wire is_cmd_w  = req_new_w & (req_kind_r == iox_pkg::REQ_CMD);
  wire is_wr_w   = req_new_w & (req_kind_r == iox_pkg::REQ_WR);
  wire is_rd_w   = req_new_w & (req_kind_r == iox_pkg::REQ_RD);
  wire is_stop_w = req_new_w & (req_kind_r == iox_pkg::REQ_STOP);
  // writes land only on the selected register; input register ignores them
  wire wr_out_w  = is_wr_w & (ptr_r == iox_pkg::REG_OUT_LEVEL);
  wire wr_inv_w  = is_wr_w & (ptr_r == iox_pkg::REG_INVERT);
  wire wr_dir_w  = is_wr_w & (ptr_r == iox_pkg::REG_DIR);
  wire [7:0] rd_mux_w = (ptr_r == iox_pkg::REG_IN_LEVEL)  ? in_level_w  :
                        (ptr_r == iox_pkg::REG_OUT_LEVEL) ? out_level_r :
                        (ptr_r == iox_pkg::REG_INVERT)    ? invert_r    : dir_r;
  // reference reload clears a pending change; first load seeds it after reset
  wire ref_load_w = ~seeded_r | is_stop_w |
                    (is_rd_w & (ptr_r == iox_pkg::REG_IN_LEVEL));

  // handshake bookkeeping and read capture
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      req_seen_r   <= 1'b0;
      ack_tgl_r    <= 1'b0;
      core_rdata_r <= 8'h00;
      seeded_r     <= 1'b0;
    end else begin
      req_seen_r <= req_s;
      ack_tgl_r  <= ack_tgl_r ^ req_new_w;
      seeded_r   <= 1'b1;
      if (is_rd_w) begin
        core_rdata_r <= rd_mux_w;
      end
    end
  end

  // pointer and the three writable registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ptr_r       <= iox_pkg::PTR_RST;
      out_level_r <= iox_pkg::OUT_LEVEL_RST;
      invert_r    <= iox_pkg::INVERT_RST;
      dir_r       <= iox_pkg::DIR_RST;
    end else begin
      if (is_cmd_w) ptr_r <= req_data_r[1:0];
      if (wr_out_w) out_level_r <= req_data_r;
      if (wr_inv_w) invert_r <= req_data_r;
      if (wr_dir_w) dir_r <= req_data_r;
    end
  end

  // open-drain interrupt: data low, enable while a change is pending
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      int_n_out    <= 1'b0;
      int_n_oe_out <= 1'b0;
    end else begin
      int_n_out    <= 1'b0;
      int_n_oe_out <= int_req_w & seeded_r; // unseeded reference must not raise a change
    end
  end

  // -----------------------------------------------------------------
  // pin cells
  // -----------------------------------------------------------------
  iox_pin_bank u_pins (
    .clk_in               (clk_in),
    .reset_n_in           (reset_n_in),
    .out_level_bits_in    (out_level_r),
    .direction_bits_in    (dir_r),
    .invert_bits_in       (invert_r),
    .ref_load_in          (ref_load_w),
    .port_pins_in         (port_pins_in),
    .port_pins_out        (port_pins_out),
    .port_pins_oe_out     (port_pins_oe_out),
    .high_side_driver_out (high_side_driver_out),
    .low_side_driver_out  (low_side_driver_out),
    .in_level_bits_out    (in_level_w),
    .int_req_out          (int_req_w)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_start_to_addr: assert property (
    @(posedge link_clk_in) disable iff (!lrst_n)
    (start_w && !stop_w) |=> (st_r == iox_pkg::LS_ADDR) && !sda_oe_out)
    else $error("start did not open an address byte");

  a_stop_to_idle: assert property (
    @(posedge link_clk_in) disable iff (!lrst_n)
    stop_w |=> (st_r == iox_pkg::LS_IDLE) && !sda_oe_out && !matched_r)
    else $error("stop did not end the transfer");

  a_addr_ack_drive: assert property (
    @(posedge link_clk_in) disable iff (!lrst_n)
    (st_r == iox_pkg::LS_ADDR && byte_done_w && addr_hit_w && !start_w && !stop_w)
      |=> sda_oe_out && (st_r == iox_pkg::LS_ACK_OUT) && (rw_r == $past(sh_r[0])))
    else $error("matching address not acknowledged");

  a_mismatch_quiet: assert property (
    @(posedge link_clk_in) disable iff (!lrst_n)
    (st_r == iox_pkg::LS_IGNORE) |=> !sda_oe_out)
    else $error("sda driven while ignoring traffic");

  a_read_capture: assert property (
    @(posedge link_clk_in) disable iff (!lrst_n)
    (st_r == iox_pkg::LS_ACK_IN && scl_rise_w && !sda_s && !start_w && !stop_w && hs_idle_w)
      |=> (req_tgl_r != $past(req_tgl_r)) && (req_kind_r == iox_pkg::REQ_RD))
    else $error("acknowledged read did not request data");

  a_cmd_ptr_load: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    is_cmd_w |=> (ptr_r == $past(req_data_r[1:0])))
    else $error("command byte not stored in pointer");

  a_input_ro: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (is_wr_w && ptr_r == iox_pkg::REG_IN_LEVEL)
      |=> $stable(out_level_r) && $stable(invert_r) && $stable(dir_r))
    else $error("write to input register changed state");

  a_reset_values: assert property (
    @(posedge clk_in)
    !reset_n_in |=> (out_level_r == iox_pkg::OUT_LEVEL_RST) &&
                   (invert_r == iox_pkg::INVERT_RST) && (dir_r == iox_pkg::DIR_RST))
    else $error("reset values wrong");

  a_pin_drivers: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    ##1 (high_side_driver_out == ($past(out_level_r) & ~$past(dir_r))) &&
        (low_side_driver_out == (~$past(out_level_r) & ~$past(dir_r))))
    else $error("pin drivers do not follow registers");

  a_input_hiz: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    ##1 ((port_pins_oe_out | high_side_driver_out | low_side_driver_out) & $past(dir_r)) == 8'h00)
    else $error("input pin has a driver on");
endmodule
`default_nettype wire

/* bench/iox_i2c_master.sv */
// serial bus master model for the expander bench
`timescale 1ns/1ps
`default_nettype none
module iox_i2c_master (
  // bus lines, sda pulled up when released
  output var logic scl_out,
  output var logic sda_low_out,
  input  wire logic sda_in
);
  localparam int T = 700;  // half bit, long enough for the crossing
  // idle bus: both lines released
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // sda moves a quarter after scl low, never near an edge
  task automatic start();
    #(T/4) sda_low_out = 1'b0;
    #(3*T/4) scl_out = 1'b1;
    #T sda_low_out = 1'b1;
    #T scl_out = 1'b0;
  endtask
  // msb first, released before the ack bit
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #(T/4) sda_low_out = ~b[i];
      #(3*T/4) scl_out = 1'b1;
      #T scl_out = 1'b0;
    end
    #(T/4) sda_low_out = 1'b0;
    #(3*T/4) scl_out = 1'b1;
    #(T/2) ack = ~sda_in;
    #(T/2) scl_out = 1'b0;
  endtask
  // last byte left unacknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    #(T/4) sda_low_out = 1'b0;
    for (int i = 0; i < 8; i++) begin
      #(3*T/4) scl_out = 1'b1;
      #(T/2) d = {d[6:0], sda_in};
      #(T/2) scl_out = 1'b0;
      #(T/4);
    end
    sda_low_out = ~last;
    #(3*T/4) scl_out = 1'b1;
    #T scl_out = 1'b0;
    #(T/4) sda_low_out = 1'b0;
  endtask
  // sda rises with scl high
  task automatic stop();
    #(T/4) sda_low_out = 1'b1;
    #(3*T/4) scl_out = 1'b1;
    #T sda_low_out = 1'b0;
    #T;
  endtask
endmodule
`default_nettype wire

/* bench/iox_expander_test.sv */
// self-checking bench for the octal i/o expander
`timescale 1ns/1ps
`default_nettype none
module iox_expander_test;
  logic clk = 0, lclk = 0, rst_n = 0, a_lo = 0, a_hi = 0, ack;
  logic [7:0] ext = 0, p_out, p_oe, hs, ls, r0, r1, o, d, n, e, x;
  logic [6:0] own;
  wire scl, m_low, oe, so, int_d, int_oe;
  int err_total = 0, tests_run = 0, cyc = 0;
  // wired-and bus with pull-up; pins show the driven level when output
  wire sda = ~(m_low | (oe & ~so));
  wire [7:0] pins = (p_oe & p_out) | (~p_oe & ext);
  // interrupt line with its pull-up: low only while enabled and driving zero
  wire int_n = ~(int_oe & ~int_d);
  // core clock, and a link clock of unrelated phase
  always #25 clk = ~clk;
  initial begin
    #3.7;
    forever #6 lclk = ~lclk;
  end
  iox_expander u_iox_expander (.clk_in(clk), .reset_n_in(rst_n), .link_clk_in(lclk),
    .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe_out(oe),
    .addr_select_low_in(a_lo), .addr_select_high_in(a_hi), .port_pins_in(pins),
    .port_pins_out(p_out), .port_pins_oe_out(p_oe), .high_side_driver_out(hs),
    .low_side_driver_out(ls), .int_n_out(int_d), .int_n_oe_out(int_oe));
  iox_i2c_master u_iox_i2c_master (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));
  // input register view: outputs read back, inputs possibly inverted
  function automatic logic [7:0] f_in(input logic [7:0] p, v, dr, ov);
    return (~dr & ov) | (dr & (p ^ v));
  endfunction
  task automatic chk_byte(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: ack %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_int(input logic got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: interrupt line %b expected %b", $time, got, exp);
    end
  endtask
  // command with junk upper bits, then two data bytes
  task automatic wr(input logic [7:0] c, v0, v1);
    u_iox_i2c_master.start();
    u_iox_i2c_master.wbyte({own, 1'b0}, ack);
    chk_ack(ack, 1'b1);
    u_iox_i2c_master.wbyte({x[7:2], c[1:0]}, ack);
    chk_ack(ack, 1'b1);
    u_iox_i2c_master.wbyte(v0, ack);
    u_iox_i2c_master.wbyte(v1, ack);
    chk_ack(ack, 1'b1);
    u_iox_i2c_master.stop();
  endtask
  // c[2] set keeps the stored pointer
  task automatic rd(input logic [2:0] c);
    if (!c[2]) begin
      u_iox_i2c_master.start();
      u_iox_i2c_master.wbyte({own, 1'b0}, ack);
      u_iox_i2c_master.wbyte({x[7:2], c[1:0]}, ack);
    end
    u_iox_i2c_master.start();
    u_iox_i2c_master.wbyte({own, 1'b1}, ack);
    chk_ack(ack, 1'b1);
    u_iox_i2c_master.rbyte(1'b0, r0);
    u_iox_i2c_master.rbyte(1'b1, r1);
    u_iox_i2c_master.stop();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, well above the expected 33k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    void'($urandom(69));
    x = $urandom;
    repeat (3) @(posedge clk);
    #2 rst_n = 1'b1;
    {a_hi, a_lo} = 2'($urandom);  // straps stay fixed for the whole run
    own = {iox_pkg::ADDR_PREFIX, a_hi, a_lo};
    repeat (10) @(posedge clk);
    chk_byte(p_oe | hs | ls, 8'h00);
    chk_byte(p_out, 8'hFF);
    chk_int(int_n, 1'b1);
    for (int k = 1; k < 4; k++) begin
      rd(3'(k));
      chk_byte(r1, (k == 2) ? 8'h00 : 8'hFF);
    end
    u_iox_i2c_master.start();
    u_iox_i2c_master.wbyte({own ^ 7'h01, 1'b0}, ack);
    chk_ack(ack, 1'b0);
    u_iox_i2c_master.stop();
    for (int i = 0; i < 3; i++) begin
      {o, d, n, e, x} = 40'({$urandom, $urandom});
      @(posedge clk);
      #2 ext = e;
      wr(8'h01, ~o, o);
      wr(8'h02, ~n, n);
      wr(8'h03, ~d, d);
      wr(8'h00, x, ~x);
      repeat (8) @(posedge clk);
      chk_byte(p_oe, ~d);
      chk_byte(hs, ~d & o);
      chk_byte(ls, ~d & ~o);
      chk_byte(p_out, o);
      rd(3'h4);
      chk_byte(r0, f_in(e, n, d, o));
      chk_byte(r1, f_in(e, n, d, o));
      // input read and stop reloaded the reference: flip every input pin, then restore
      @(posedge clk);
      #2 ext = ~e;
      repeat (6) @(posedge clk);
      chk_int(int_n, ~|d);
      #2 ext = e;
      repeat (6) @(posedge clk);
      chk_int(int_n, 1'b1);
      rd(3'h1);
      chk_byte(r0, o);
      chk_byte(r1, o);
      rd(3'h2);
      chk_byte(r1, n);
      rd(3'h3);
      chk_byte(r1, d);
    end
    complete_run();
  end
endmodule
`default_nettype wire
